//--- pkg/flash_mode_pkg.sv
// package: constants for the flash mode timer
// assumes a 20 MHz system clock
package flash_mode_pkg;
    // ****************************************************************
    // operating modes and timing
    // ****************************************************************
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_TORCH    = 2'h1;
    localparam logic [1:0] MODE_FLASH    = 2'h2;
    localparam logic [1:0] MODE_VOLTAGE  = 2'h3;
    localparam logic [1:0] BOOST_BYPASS  = 2'h3;
    localparam logic [2:0] DIM_RESET_CODE = 3'h6;
    localparam int CLK_HZ        = 20000000;
    localparam int TICK_US       = 1000;
    localparam int TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
    localparam int GP_UNIT_MS    = 1020;
    localparam int MEAS_DELAY_MS = 10;
    localparam int PWM_HZ        = 122;
    localparam int PWM_CYCLES    = CLK_HZ / PWM_HZ;
    localparam int DUTY_DENOM    = 1000;
    // duty steps in tenths of a percent
    localparam int DUTY_0 = 8;
    localparam int DUTY_1 = 16;
    localparam int DUTY_2 = 23;
    localparam int DUTY_3 = 31;
    localparam int DUTY_4 = 39;
    localparam int DUTY_5 = 47;
    localparam int DUTY_6 = 63;
    localparam int DUTY_7 = 86;
endpackage : flash_mode_pkg

//--- logic/flash_mode_timer.sv
// flash mode timer: mode decode, safety timer, general timer, dimming, measurement start
// assumes control bits come from a register file elsewhere; inputs synchronous except trigger
`timescale 1ns/1ps
`default_nettype none
module flash_mode_timer
    import flash_mode_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int PWM_LEN  = PWM_CYCLES
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // control bits
    input  wire logic [1:0] mode_select,
    input  wire logic [1:0] boost_voltage_select,
    input  wire logic [2:0] torch_level_code,
    input  wire logic [2:0] flash_level_code,
    input  wire logic       strobe_trigger_type,
    input  wire logic [4:0] flash_time_limit,
    input  wire logic [2:0] dim_duty_timer_code,
    input  wire logic       low_light_pwm_enable,
    input  wire logic       software_flash_start_set,
    input  wire logic       measure_request,
    input  wire logic       expiry_flag_clear,
    input  wire logic       gpio_is_blanking,
    // pins
    input  wire logic       flash_trigger,
    input  wire logic       gpio_in,
    input  wire logic       hw_voltage_mode_input,
    // status and drive
    output logic            software_flash_start,
    output logic            expiry_flag,
    output logic            current_regulation_mode,
    output logic            voltage_regulation_mode,
    output logic            led_sink_on,
    output logic [2:0]      led_level_code,
    output logic            led_flash_level,
    output logic            rectifier_on,
    output logic            safety_timer_running,
    output logic            measure_sample
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] duty_cycles(input logic [2:0] code);
        int d;
        d = DUTY_0;
        case (code)
            3'h0: d = DUTY_0;
            3'h1: d = DUTY_1;
            3'h2: d = DUTY_2;
            3'h3: d = DUTY_3;
            3'h4: d = DUTY_4;
            3'h5: d = DUTY_5;
            3'h6: d = DUTY_6;
            default: d = DUTY_7;
        endcase
        return 32'((PWM_LEN / DUTY_DENOM) * d);
    endfunction : duty_cycles

    // ****************************************************************
    // sync, prescaler and edges
    // ****************************************************************
    logic        trig_s1_q, trig_s2_q, trig_s3_q;
    logic        start_prev_q;
    logic [31:0] tick_cnt_q;
    logic        tick;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= flash_trigger;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tick_cnt_q <= '0;
        end else if (tick_cnt_q == 32'(TICK_LEN - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end
    assign tick = (tick_cnt_q == 32'(TICK_LEN - 1));
    logic trig_rise, start_rise, any_high, any_rise, timeout;
    assign trig_rise  = trig_s2_q & ~trig_s3_q;
    assign start_rise = software_flash_start & ~start_prev_q;
    assign any_high   = trig_s2_q | software_flash_start;
    assign any_rise   = trig_rise | start_rise;

    // ****************************************************************
    // safety timer
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_HOLD} flash_state_type;
    flash_state_type st_q;
    logic [31:0] safety_ms_q;
    logic [31:0] limit_ms;
    // limit field counted in 32 ms steps beyond a 32 ms floor
    assign limit_ms = 32'({27'h0, flash_time_limit} + 32'h1) * 32'h20;
    assign timeout  = (st_q == ST_FLASH) && tick && (safety_ms_q + 32'h1 >= limit_ms);
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_q        <= ST_IDLE;
            safety_ms_q <= '0;
        end else if (mode_select != MODE_FLASH) begin
            st_q        <= ST_IDLE;
            safety_ms_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (any_rise) begin
                        st_q        <= ST_FLASH;
                        safety_ms_q <= '0;
                    end
                end
                ST_FLASH: begin
                    // blanking is not looked at here on purpose
                    if (timeout) begin
                        st_q <= (strobe_trigger_type) ? ST_IDLE : ST_HOLD;
                    end else if (!strobe_trigger_type && !any_high) begin
                        st_q <= ST_IDLE;
                    end else if (tick) begin
                        safety_ms_q <= safety_ms_q + 32'h1;
                    end
                end
                ST_HOLD: begin
                    // level type after timeout waits for triggers to drop
                    if (!any_high) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // software start bit and general timer
    // ****************************************************************
    logic        gp_run_q;
    logic [31:0] gp_ms_q;
    logic        gp_done;
    assign gp_done = gp_run_q && tick &&
        (gp_ms_q + 32'h1 >= 32'({29'h0, dim_duty_timer_code}) * 32'(GP_UNIT_MS));
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            software_flash_start <= 1'b0;
            start_prev_q         <= 1'b0;
        end else begin
            start_prev_q <= software_flash_start;
            if (timeout || gp_done) begin
                software_flash_start <= 1'b0;
            end else if (software_flash_start_set) begin
                software_flash_start <= 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gp_run_q <= 1'b0;
            gp_ms_q  <= '0;
        end else if (mode_select != MODE_VOLTAGE) begin
            gp_run_q <= 1'b0;
            gp_ms_q  <= '0;
        end else if (!gp_run_q && start_rise) begin
            gp_run_q <= 1'b1;
            gp_ms_q  <= '0;
        end else if (gp_done) begin
            gp_run_q <= 1'b0;
        end else if (gp_run_q && tick) begin
            gp_ms_q <= gp_ms_q + 32'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            expiry_flag <= 1'b0;
        end else if (gp_done || timeout) begin
            expiry_flag <= 1'b1; // set wins over clear
        end else if (expiry_flag_clear) begin
            expiry_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // dimming pwm
    // ****************************************************************
    logic [31:0] pwm_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pwm_cnt_q <= '0;
        end else if (pwm_cnt_q == 32'(PWM_LEN - 1)) begin
            pwm_cnt_q <= '0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 32'h1;
        end
    end
    logic dim_on;
    assign dim_on = (mode_select == MODE_TORCH) && low_light_pwm_enable;
    logic pwm_high;
    assign pwm_high = pwm_cnt_q < duty_cycles(dim_duty_timer_code);

    // ****************************************************************
    // drive decode
    // ****************************************************************
    logic flash_now, blank, sink_d, volt_mode_d;
    assign blank     = gpio_is_blanking && gpio_in;
    assign flash_now = (st_q == ST_FLASH) && !blank;
    assign volt_mode_d = (mode_select == MODE_VOLTAGE) || hw_voltage_mode_input;
    assign sink_d    = (mode_select == MODE_TORCH) ? (!dim_on || pwm_high) :
                       (mode_select == MODE_FLASH);
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            current_regulation_mode <= 1'b0;
            voltage_regulation_mode <= 1'b0;
            led_sink_on             <= 1'b0;
            led_level_code          <= 3'h0;
            led_flash_level         <= 1'b0;
            rectifier_on            <= 1'b0;
            safety_timer_running    <= 1'b0;
        end else begin
            voltage_regulation_mode <= volt_mode_d;
            current_regulation_mode <= !volt_mode_d && sink_d;
            led_sink_on             <= sink_d;
            led_flash_level         <= flash_now;
            led_level_code          <= flash_now ? flash_level_code : torch_level_code;
            rectifier_on            <= (mode_select == MODE_SHUTDOWN) && !hw_voltage_mode_input &&
                                       (boost_voltage_select == BOOST_BYPASS);
            safety_timer_running    <= (st_q == ST_FLASH);
        end
    end

    // ****************************************************************
    // forward-voltage measurement start
    // ****************************************************************
    logic        meas_run_q;
    logic [31:0] meas_ms_q;
    logic        meas_go;
    assign meas_go = (mode_select == MODE_FLASH && st_q == ST_IDLE && any_rise) ||
                     (measure_request && (mode_select == MODE_TORCH || mode_select == MODE_FLASH));
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            meas_run_q     <= 1'b0;
            meas_ms_q      <= '0;
            measure_sample <= 1'b0;
        end else begin
            measure_sample <= 1'b0;
            if (meas_go && !meas_run_q) begin
                meas_run_q <= 1'b1;
                meas_ms_q  <= '0;
            end else if (meas_run_q && tick) begin
                if (meas_ms_q + 32'h1 >= 32'(MEAS_DELAY_MS)) begin
                    meas_run_q     <= 1'b0;
                    measure_sample <= 1'b1;
                end else begin
                    meas_ms_q <= meas_ms_q + 32'h1;
                end
            end
        end
    end
endmodule : flash_mode_timer
`default_nettype wire

//--- verif/strobe_model.sv
// camera side: drives the flash trigger pin and the blanking pin
// assumes tasks are called from the bench at a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module strobe_model (
    // clock
    input  wire logic sys_clk,
    // pins toward the device, both idle low
    output logic      flash_trigger,
    output logic      gpio_in
);
    initial flash_trigger = 1'b0;
    initial gpio_in = 1'b0;
    task automatic strobe(input int w);
        flash_trigger = 1'b1;
        repeat (w) @(negedge sys_clk);
        flash_trigger = 1'b0;
    endtask : strobe
    task automatic blank(input int w);
        gpio_in = 1'b1;
        repeat (w) @(negedge sys_clk);
        gpio_in = 1'b0;
    endtask : blank
endmodule : strobe_model
`default_nettype wire

//--- verif/flash_mode_checker.sv
// checker: mode decode and timer relations at the flash timer ports
// assumes bind onto flash_mode_timer, single clock domain
`timescale 1ns/1ps
`default_nettype none
module flash_mode_checker
    import flash_mode_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic [1:0] mode_select,
    input wire logic [1:0] boost_voltage_select,
    input wire logic       flash_trigger,
    input wire logic       gpio_is_blanking,
    input wire logic       gpio_in,
    input wire logic       hw_voltage_mode_input,
    input wire logic       software_flash_start,
    input wire logic       expiry_flag,
    input wire logic       voltage_regulation_mode,
    input wire logic       led_sink_on,
    input wire logic       led_flash_level,
    input wire logic       rectifier_on,
    input wire logic       safety_timer_running
);
    // ****************************************************************
    // relations
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_off_dark: assert property ((mode_select == MODE_SHUTDOWN)[*3] |-> !led_sink_on)
        else $error("led driven in shutdown");
    a_torch_steady: assert property ((mode_select == MODE_TORCH)[*3] |-> !led_flash_level)
        else $error("flash level in torch mode");
    a_volt_dark: assert property ((mode_select == MODE_VOLTAGE)[*3]
        |-> voltage_regulation_mode && !led_sink_on) else $error("voltage mode wrong");
    a_hw_forces: assert property (hw_voltage_mode_input[*3] |-> voltage_regulation_mode)
        else $error("hw input did not force voltage mode");
    a_rect_bypass: assert property ((mode_select == MODE_SHUTDOWN && !hw_voltage_mode_input
        && boost_voltage_select == BOOST_BYPASS)[*3] |-> rectifier_on) else $error("no bypass");
    a_leave_flash: assert property ((mode_select != MODE_FLASH)[*3] |-> !safety_timer_running)
        else $error("safety timer outside flash mode");
    a_start_cleared: assert property ($rose(expiry_flag) && mode_select == MODE_FLASH
        |-> ##[0:1] !software_flash_start) else $error("start bit kept after timeout");
    a_blank_torch: assert property ((gpio_is_blanking && gpio_in)[*3] |-> !led_flash_level)
        else $error("flash level while blanked");
    // flash level only two edges after flash mode was seen, and always with the timer
    a_flash_timed: assert property (led_flash_level
        |-> safety_timer_running && $past(mode_select, 2) == MODE_FLASH)
        else $error("flash level without timer or flash mode");
    a_trig_starts: assert property (($rose(flash_trigger) && mode_select == MODE_FLASH
        && !safety_timer_running) ##1 (mode_select == MODE_FLASH && flash_trigger)[*5]
        |-> safety_timer_running) else $error("trigger edge did not start timer");
    c_expiry: cover property ($rose(expiry_flag));
    c_blanked: cover property (safety_timer_running && gpio_in && gpio_is_blanking);
    c_stop: cover property ($fell(safety_timer_running));
endmodule : flash_mode_checker
bind flash_mode_timer flash_mode_checker i_chk (.*);
`default_nettype wire

//--- verif/tb_flash_mode_timer.sv
// bench: mode table, then flash, timer, measurement and dimming cases
// assumes short tick (4 cycles) and pwm period (1000 cycles) parameters
`timescale 1ns/1ps
`default_nettype none
module tb_flash_mode_timer
    import flash_mode_pkg::*;
;
    localparam int TL = 4;
    localparam int PL = 1000;
    localparam int LIM = 32 * TL;
    logic       sys_clk = 1'b0, nrst = 1'b0, hw_voltage_mode_input = 1'b0;
    logic [1:0] mode_select = 2'h0, boost_voltage_select = 2'h0;
    logic [2:0] dim_duty_timer_code = DIM_RESET_CODE, led_level_code;
    logic [2:0] torch_level_code = 3'h5, flash_level_code = 3'h6;
    logic [4:0] flash_time_limit = 5'h00;
    logic       strobe_trigger_type = 1'b0, low_light_pwm_enable = 1'b0;
    logic       software_flash_start_set = 1'b0, measure_request = 1'b0;
    logic       expiry_flag_clear = 1'b0, gpio_is_blanking = 1'b0;
    wire logic  flash_trigger, gpio_in;
    logic       software_flash_start, expiry_flag, current_regulation_mode, measure_sample;
    logic       voltage_regulation_mode, led_sink_on, led_flash_level, rectifier_on;
    logic       safety_timer_running;
    int         err_count = 0, n_checks = 0, n;
    // rows: mode, boost select, hw input | voltage mode, current mode, sink, rectifier
    logic [8:0] rows [9] = '{9'h061, 9'h020, 9'h086, 9'h106, 9'h1C8,
                             9'h038, 9'h0BA, 9'h13A, 9'h1B8};
    flash_mode_timer #(.TICK_LEN(TL), .PWM_LEN(PL)) i_dut (.*);
    strobe_model i_cam (.sys_clk(sys_clk), .flash_trigger(flash_trigger), .gpio_in(gpio_in));
    initial forever #25 sys_clk = ~sys_clk;
    task chk_val(input logic [2:0] g, input logic [2:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk_val
    task chk_rng(input int g, input int lo, input int hi, input string m);
        chk_val(3'(g >= lo && g <= hi), 3'h1, m);
    endtask : chk_rng
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    // bounded wait, so a stuck output ends as a failed range check
    task automatic wait_lvl(ref logic s, input logic v, output int c);
        c = 0;
        while (s !== v && c < 9000) begin
            cyc(1);
            c++;
        end
    endtask : wait_lvl
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        report_and_stop();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        cyc(2);
        chk_val(led_sink_on, 1'b0, "sink in reset");
        chk_val(expiry_flag, 1'b0, "flag in reset");
        nrst = 1'b1;
        for (int i = 0; i < 9; i++) begin
            {mode_select, boost_voltage_select, hw_voltage_mode_input} = rows[i][8:4];
            cyc(4);
            chk_val(voltage_regulation_mode, rows[i][3], "voltage mode");
            chk_val(current_regulation_mode, rows[i][2], "current mode");
            chk_val(led_sink_on, rows[i][1], "sink");
            chk_val(rectifier_on, rows[i][0], "rectifier");
        end
        {mode_select, boost_voltage_select, hw_voltage_mode_input} = 5'h10;
        cyc(4);
        pulse(software_flash_start_set);
        cyc(4);
        chk_val(led_level_code, 3'h6, "flash code");
        wait_lvl(safety_timer_running, 1'b0, n);
        chk_rng(n, LIM - TL - 8, LIM + TL, "level limit");
        chk_val(software_flash_start, 1'b0, "start kept");
        chk_val(led_flash_level, 1'b0, "not torch");
        pulse(expiry_flag_clear);
        cyc(2);
        chk_val(expiry_flag, 1'b0, "flag kept");
        flash_level_code = 3'h3;
        fork
            i_cam.strobe(30);
            begin
                cyc(10);
                chk_val(led_flash_level, 1'b1, "no flash");
                chk_val(led_level_code, 3'h3, "new flash code");
            end
        join
        cyc(6);
        chk_val(safety_timer_running, 1'b0, "timer kept");
        strobe_trigger_type = 1'b1;
        gpio_is_blanking = 1'b1;
        cyc(2);
        fork
            begin
                wait_lvl(safety_timer_running, 1'b1, n);
                wait_lvl(safety_timer_running, 1'b0, n);
            end
            begin
                i_cam.strobe(8);
                cyc(15);
                i_cam.blank(20);
                i_cam.strobe(8);
            end
        join
        chk_rng(n, LIM - TL - 2, LIM + TL + 2, "edge length");
        gpio_is_blanking = 1'b0;
        pulse(expiry_flag_clear);
        mode_select = MODE_VOLTAGE;
        dim_duty_timer_code = 3'h1;
        cyc(3);
        pulse(software_flash_start_set);
        wait_lvl(expiry_flag, 1'b1, n);
        chk_rng(n, GP_UNIT_MS * TL - TL - 4, GP_UNIT_MS * TL + TL + 4, "gp timer");
        mode_select = MODE_TORCH;
        dim_duty_timer_code = DIM_RESET_CODE;
        torch_level_code = 3'h2;
        cyc(3);
        chk_val(led_level_code, 3'h2, "torch code");
        pulse(measure_request);
        wait_lvl(measure_sample, 1'b1, n);
        chk_rng(n, MEAS_DELAY_MS * TL - TL - 4, MEAS_DELAY_MS * TL + TL + 4, "sample");
        low_light_pwm_enable = 1'b1;
        dim_duty_timer_code = 3'h7;
        for (int m = 1; m <= 2; m++) begin
            mode_select = 2'(m);
            cyc(PL);
            n = 0;
            repeat (PL) begin
                cyc(1);
                n += int'(led_sink_on === 1'b1);
            end
            if (m == 1) chk_rng(n, DUTY_7 - 3, DUTY_7 + 3, "duty");
            else chk_rng(n, PL, PL, "dim outside torch");
        end
        pulse(software_flash_start_set);
        cyc(10);
        mode_select = MODE_TORCH;
        cyc(3);
        chk_val(safety_timer_running, 1'b0, "timer after leave");
        // mid-run reset: start bit left high must not come back as a flash
        nrst = 1'b0;
        cyc(2);
        chk_val(software_flash_start, 1'b0, "start in reset");
        nrst = 1'b1;
        mode_select = MODE_FLASH;
        cyc(3);
        chk_val(led_sink_on, 1'b1, "sink after reset");
        chk_val(led_flash_level, 1'b0, "flash after reset");
        pulse(software_flash_start_set);
        cyc(4);
        chk_val(led_flash_level, 1'b1, "start after reset");
        report_and_stop();
    end
endmodule : tb_flash_mode_timer
`default_nettype wire
